// ==== logic/operand_address_unit.v ====
// Purpose: Two operand address generators (data side and program side) with circular wrap.
// Assumes: Decode presents one access per generator per cycle; the program keeps buffers inside one page.
// Notes: Addresses and updated pointers appear one cycle after the access request.
`timescale 1ns/100ps
`default_nettype none
`include "operand_address_unit_consts.vh"

// One generator with primary and secondary register sets.
module address_gen_core #(
  parameter PTR_W = 16,
  parameter PAGE_W = 8
) (
  input wire clk,
  input wire srst,
  input wire set_sel,
  input wire acc_en,
  input wire [1:0] acc_ptr,
  input wire [1:0] acc_mod,
  input wire acc_use_imm,
  input wire [7:0] acc_imm,
  input wire [1:0] acc_mode,
  input wire wr_en,
  input wire [2:0] wr_kind,
  input wire [1:0] wr_idx,
  input wire [PTR_W-1:0] wr_data,
  output reg [PAGE_W+PTR_W-1:0] addr_q,
  output reg addr_valid_q,
  output reg [PTR_W-1:0] rd_ptr_q
);
  localparam NREG = 2 * `NUM_PTR;
  // Register files are indexed by {set, index}; the upper half is the secondary set.
  reg [PTR_W-1:0] ptr_q [0:NREG-1];
  reg [PTR_W-1:0] mod_q [0:NREG-1];
  reg [PTR_W-1:0] len_q [0:NREG-1];
  reg [PTR_W-1:0] base_q [0:NREG-1];
  reg [PAGE_W-1:0] page_q [0:1];
  wire [2:0] ai = {set_sel, acc_ptr};
  wire [2:0] mi = {set_sel, acc_mod};
  wire [2:0] wi = {set_sel, wr_idx};
  // The immediate is sign-extended so that a negative offset walks the pointer down.
  wire [PTR_W-1:0] offs = acc_use_imm ? {{(PTR_W-8){acc_imm[7]}}, acc_imm} : mod_q[mi];
  wire [PTR_W-1:0] cur = ptr_q[ai];
  wire [PTR_W-1:0] len = len_q[ai];
  wire [PTR_W-1:0] base = base_q[ai];
  wire circ_on = (len != {PTR_W{1'b0}});
  reg [PTR_W-1:0] raw_d;
  reg [PTR_W-1:0] rel_d;
  reg below_d;
  reg beyond_d;
  reg [PTR_W-1:0] next_d;
  integer i;

  // Circular wrap relative to base; length zero means linear update.
  // Only one correction is applied, so an offset must stay smaller than the length.
  always @*
  begin
    raw_d = cur + offs;
    rel_d = raw_d - base;
    below_d = (raw_d < base);
    beyond_d = (rel_d >= len);
    next_d = raw_d;
    if (circ_on)
    begin
      if (below_d)
        next_d = raw_d + len;
      else if (beyond_d)
        next_d = raw_d - len;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      // Both register sets clear together.
      for (i = 0; i < NREG; i = i + 1)
      begin
        ptr_q[i] <= {PTR_W{1'b0}};
        mod_q[i] <= {PTR_W{1'b0}};
        len_q[i] <= {PTR_W{1'b0}};
        base_q[i] <= {PTR_W{1'b0}};
      end
      page_q[0] <= `RESET_PAGE;
      page_q[1] <= `RESET_PAGE;
      addr_q <= {(PAGE_W+PTR_W){1'b0}};
      addr_valid_q <= 1'b0;
      rd_ptr_q <= {PTR_W{1'b0}};
    end
    else
    begin
      addr_valid_q <= acc_en;
      // Readback follows the selected pointer every cycle, showing its value before this access.
      rd_ptr_q <= cur;
      // A write and an access to one pointer in the same cycle: a post or pre-update access, assigned later, wins.
      if (wr_en)
      begin
        case (wr_kind)
          `WR_PTR: ptr_q[wi] <= wr_data;
          `WR_MOD: mod_q[wi] <= wr_data;
          `WR_LEN: len_q[wi] <= wr_data;
          `WR_BASE: base_q[wi] <= wr_data;
          `WR_PAGE: page_q[set_sel] <= wr_data[PAGE_W-1:0];
          default: ;
        endcase
      end
      // The page of the current set supplies the upper address bits.
      if (acc_en)
      begin
        case (acc_mode)
          `MODE_POST:
          begin
            addr_q <= {page_q[set_sel], cur};
            ptr_q[ai] <= next_d;
          end
          `MODE_PRE_UPD:
          begin
            addr_q <= {page_q[set_sel], next_d};
            ptr_q[ai] <= next_d;
          end
          `MODE_PRE_KEEP:
            addr_q <= {page_q[set_sel], next_d};
          `MODE_DIRECT:
            addr_q <= {page_q[set_sel], cur};
          default:
            addr_q <= {page_q[set_sel], cur};
        endcase
      end
    end
  end
endmodule

// Operation
// - Each generator holds four 16-bit pointers, read out and updated.
// - Indirect access modifies pointer pre or post using one of four modifiers.
// - Premodify option uses pointer plus modifier as address, pointer unchanged.
// - Signed 8-bit immediate offset may replace modifier, pre or post.
// - With length and base set, updates wrap modulo length from base.
// - Circular buffers stay within one 64K-word page of 256.
// - Secondary copy of all registers gives fast context switch.
// - Both generators form addresses in the same cycle.
// - Each generator's 8-bit page register forms the upper bits of 24-bit address.
// - Pointers give low 16 bits; software sets page register beforehand.
module operand_address_unit #(
  parameter PTR_W = `PTR_W,
  parameter PAGE_W = `PAGE_W
) (
  input wire clk,
  input wire srst,
  input wire set_sel,
  input wire dm_acc_en,
  input wire [1:0] dm_acc_ptr,
  input wire [1:0] dm_acc_mod,
  input wire dm_acc_use_imm,
  input wire [7:0] dm_acc_imm,
  input wire [1:0] dm_acc_mode,
  input wire dm_wr_en,
  input wire [2:0] dm_wr_kind,
  input wire [1:0] dm_wr_idx,
  input wire [PTR_W-1:0] dm_wr_data,
  input wire pm_acc_en,
  input wire [1:0] pm_acc_ptr,
  input wire [1:0] pm_acc_mod,
  input wire pm_acc_use_imm,
  input wire [7:0] pm_acc_imm,
  input wire [1:0] pm_acc_mode,
  input wire pm_wr_en,
  input wire [2:0] pm_wr_kind,
  input wire [1:0] pm_wr_idx,
  input wire [PTR_W-1:0] pm_wr_data,
  output wire [PAGE_W+PTR_W-1:0] dm_addr_q,
  output wire dm_addr_valid_q,
  output wire [PTR_W-1:0] dm_rd_ptr_q,
  output wire [PAGE_W+PTR_W-1:0] pm_addr_q,
  output wire pm_addr_valid_q,
  output wire [PTR_W-1:0] pm_rd_ptr_q
);
  // Two independent generators run side by side for dual fetches.
  // Outputs come straight from each generator's registers.
  address_gen_core #(
    .PTR_W(PTR_W),
    .PAGE_W(PAGE_W)
  ) u_dm (
    .clk(clk),
    .srst(srst),
    .set_sel(set_sel),
    .acc_en(dm_acc_en),
    .acc_ptr(dm_acc_ptr),
    .acc_mod(dm_acc_mod),
    .acc_use_imm(dm_acc_use_imm),
    .acc_imm(dm_acc_imm),
    .acc_mode(dm_acc_mode),
    .wr_en(dm_wr_en),
    .wr_kind(dm_wr_kind),
    .wr_idx(dm_wr_idx),
    .wr_data(dm_wr_data),
    .addr_q(dm_addr_q),
    .addr_valid_q(dm_addr_valid_q),
    .rd_ptr_q(dm_rd_ptr_q)
  );

  // The program side shares the set select, so one level change switches both contexts.
  address_gen_core #(
    .PTR_W(PTR_W),
    .PAGE_W(PAGE_W)
  ) u_pm (
    .clk(clk),
    .srst(srst),
    .set_sel(set_sel),
    .acc_en(pm_acc_en),
    .acc_ptr(pm_acc_ptr),
    .acc_mod(pm_acc_mod),
    .acc_use_imm(pm_acc_use_imm),
    .acc_imm(pm_acc_imm),
    .acc_mode(pm_acc_mode),
    .wr_en(pm_wr_en),
    .wr_kind(pm_wr_kind),
    .wr_idx(pm_wr_idx),
    .wr_data(pm_wr_data),
    .addr_q(pm_addr_q),
    .addr_valid_q(pm_addr_valid_q),
    .rd_ptr_q(pm_rd_ptr_q)
  );
endmodule
`default_nettype wire

// ==== logic/operand_address_unit_consts.vh ====
// Purpose: Constants for the operand address unit pair.
// Assumes: Single core clock, synchronous active-high reset.
// Notes: Mode codes select how an indirect access forms its address.
`ifndef OPERAND_ADDRESS_UNIT_CONSTS_VH
`define OPERAND_ADDRESS_UNIT_CONSTS_VH
`define PTR_W 16
`define PAGE_W 8
`define ADDR_W 24
`define IMM_W 8
`define NUM_PTR 4
`define SEL_W 2
`define MODE_W 2
`define MODE_POST 2'h0
`define MODE_PRE_UPD 2'h1
`define MODE_PRE_KEEP 2'h2
`define MODE_DIRECT 2'h3
`define WR_PTR 3'h0
`define WR_MOD 3'h1
`define WR_LEN 3'h2
`define WR_BASE 3'h3
`define WR_PAGE 3'h4
`define RESET_PAGE 8'h00
`endif

// ==== test/operand_address_unit_props.sv ====
// Purpose: Port checks for the operand address unit.
// Assumes: One clock; srst high resets.
// Notes: Bound to the top module.
`timescale 1ns/100ps
`default_nettype none
module oau_props(
  input wire logic clk,
  input wire logic srst,
  input wire logic dm_acc_en,
  input wire logic pm_acc_en,
  input wire logic [1:0] dm_acc_mode,
  input wire logic [23:0] dm_addr_q,
  input wire logic [23:0] pm_addr_q,
  input wire logic dm_addr_valid_q,
  input wire logic pm_addr_valid_q,
  input wire logic [15:0] dm_rd_ptr_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_dm_answer: assert property (dm_acc_en |=> dm_addr_valid_q) else $error("dm late");
  a_dm_quiet: assert property (!dm_acc_en |=> !dm_addr_valid_q) else $error("dm extra");
  a_pm_answer: assert property (pm_acc_en |=> pm_addr_valid_q) else $error("pm late");
  a_pm_quiet: assert property (!pm_acc_en |=> !pm_addr_valid_q) else $error("pm extra");
  a_dual_fetch: assert property (dm_acc_en && pm_acc_en |=> dm_addr_valid_q && pm_addr_valid_q) else $error("dual");
  a_dm_hold: assert property (!dm_acc_en |=> $stable(dm_addr_q)) else $error("dm moved");
  a_pm_hold: assert property (!pm_acc_en |=> $stable(pm_addr_q)) else $error("pm moved");
  a_post_addr: assert property (dm_acc_en && dm_acc_mode == 2'h0 |=> dm_addr_q[15:0] == dm_rd_ptr_q)
    else $error("post addr");
  c_keep: cover property (dm_acc_en && dm_acc_mode == 2'h2);
  c_dual: cover property (dm_acc_en && pm_acc_en);
  c_pre: cover property (dm_acc_en && dm_acc_mode == 2'h1);
endmodule
bind operand_address_unit oau_props i_oau_props(
  .clk(clk),
  .srst(srst),
  .dm_acc_en(dm_acc_en),
  .pm_acc_en(pm_acc_en),
  .dm_acc_mode(dm_acc_mode),
  .dm_addr_q(dm_addr_q),
  .pm_addr_q(pm_addr_q),
  .dm_addr_valid_q(dm_addr_valid_q),
  .pm_addr_valid_q(pm_addr_valid_q),
  .dm_rd_ptr_q(dm_rd_ptr_q)
);
`default_nettype wire

// ==== test/decode_model.sv ====
// Purpose: Program-side decode issuing operand accesses.
// Assumes: Request word changes just after a rising edge.
// Notes: Idle fields carry inverted stale values, never a clean zero.
`timescale 1ns/100ps
`default_nettype none
module decode_model(
  input wire logic [15:0] ins,
  output logic [15:0] acc
);
  logic [14:0] last = 15'h0;
  always @* if (ins[15]) last = ins[14:0];
  assign acc = ins[15] ? ins : {1'b0, ~last};
endmodule
`default_nettype wire

// ==== test/test_operand_address_unit.sv ====
// Purpose: Self-checking bench for the operand address unit.
// Assumes: Addresses answer one cycle after a request.
// Notes: Expected addresses queue per side.
`timescale 1ns/100ps
`default_nettype none
module test_operand_address_unit;
  logic clk = 0, srst = 1, set_sel = 0;
  logic [15:0] da = 0, pi = 0, pa, r;
  logic [21:0] dw = 0, pw = 0;
  logic [39:0] dq[$], pq[$];
  logic [39:0] de, pe;
  wire [23:0] d_a, p_a;
  wire [15:0] d_r, p_r;
  wire d_v, p_v;
  int n_errors = 0, compares = 0, cyc = 0;
  always #5 clk = ~clk;
  decode_model i_decode_model(.ins(pi), .acc(pa));
  operand_address_unit i_operand_address_unit(.clk(clk), .srst(srst), .set_sel(set_sel),
    .dm_acc_en(da[15]), .dm_acc_ptr(da[14:13]), .dm_acc_mod(da[12:11]), .dm_acc_use_imm(da[10]),
    .dm_acc_imm(da[9:2]), .dm_acc_mode(da[1:0]), .dm_wr_en(dw[21]), .dm_wr_kind(dw[20:18]),
    .dm_wr_idx(dw[17:16]), .dm_wr_data(dw[15:0]), .pm_acc_en(pa[15]), .pm_acc_ptr(pa[14:13]),
    .pm_acc_mod(pa[12:11]), .pm_acc_use_imm(pa[10]), .pm_acc_imm(pa[9:2]), .pm_acc_mode(pa[1:0]),
    .pm_wr_en(pw[21]), .pm_wr_kind(pw[20:18]), .pm_wr_idx(pw[17:16]), .pm_wr_data(pw[15:0]),
    .dm_addr_q(d_a), .dm_addr_valid_q(d_v), .dm_rd_ptr_q(d_r), .pm_addr_q(p_a), .pm_addr_valid_q(p_v),
    .pm_rd_ptr_q(p_r));
  function logic [15:0] aw(input logic [1:0] p, m, input logic u, input logic [7:0] i, input logic [1:0] md);
    return {1'b1, p, m, u, i, md};
  endfunction
  function logic [21:0] ww(input logic [2:0] k, input logic [1:0] x, input logic [15:0] d);
    return {1'b1, k, x, d};
  endfunction
  task chk(input string n, input logic [23:0] e, g);
    compares++;
    if (e !== g)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_ptr(input string n, input logic [15:0] e, g);
    compares++;
    if (e !== g)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task c(input logic [15:0] a, input logic [21:0] w, input logic [39:0] e,
         input logic [15:0] b, input logic [21:0] v, input logic [39:0] f);
    da = a;
    dw = w;
    pi = b;
    pw = v;
    if (a[15]) dq.push_back(e);
    if (b[15]) pq.push_back(f);
    @(posedge clk);
    #1;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 500)
    begin
      n_errors++;
      stop_test;
    end
    if (d_v === 1'b1)
    begin
      de = dq.pop_front();
      chk("dm_addr", de[23:0], d_a);
      chk_ptr("dm_rd_ptr", de[39:24], d_r);
    end
    if (p_v === 1'b1)
    begin
      pe = pq.pop_front();
      chk("pm_addr", pe[23:0], p_a);
      chk_ptr("pm_rd_ptr", pe[39:24], p_r);
    end
  end
  initial
  begin
    void'($urandom(6730));
    r = 16'($urandom % 16);
    repeat (16) @(posedge clk);
    #1 srst = 0;
    c(0, ww(4, 0, 16'h4), 0, 0, ww(4, 0, 16'h7), 0);
    c(0, ww(0, 0, 16'h10), 0, 0, ww(0, 3, 16'h100), 0);
    c(aw(0, 0, 1, 8'h03, 0), 0, {16'h10, 24'h040010}, 0, 0, 0);
    c(aw(0, 0, 1, 8'hfe, 2), 0, {16'h13, 24'h040011}, 0, 0, 0);
    c(aw(0, 0, 0, 0, 3), ww(3, 1, 16'h10), {16'h13, 24'h040013}, 0, 0, 0);
    // Buffer kept inside one page.
    c(0, ww(2, 1, 16'h8), 0, 0, 0, 0);
    c(0, ww(0, 1, 16'h16), 0, 0, 0, 0);
    c(aw(1, 0, 1, 8'h03, 0), ww(1, 2, r), {16'h16, 24'h040016}, 0, 0, 0);
    c(aw(1, 0, 1, 8'hfe, 1), 0, {16'h11, 24'h040017}, 0, 0, 0);
    c(aw(0, 2, 0, 0, 1), 0, {16'h13, 8'h04, 16'h13 + r}, aw(3, 0, 1, 8'h01, 0), 0, {16'h100, 24'h070100});
    set_sel = 1;
    c(aw(0, 0, 0, 0, 3), ww(0, 0, 16'h55), {16'h0, 24'h0}, 0, 0, 0);
    c(aw(0, 0, 0, 0, 3), 0, {16'h55, 24'h000055}, 0, 0, 0);
    set_sel = 0;
    c(aw(0, 0, 0, 0, 3), 0, {16'h13 + r, 8'h04, 16'h13 + r}, aw(3, 0, 0, 0, 3), 0, {16'h101, 24'h070101});
    c(0, 0, 0, 0, 0, 0);
    c(0, 0, 0, 0, 0, 0);
    stop_test;
  end
endmodule
`default_nettype wire
